// ===== rtl/frl_limiter.sv
`timescale 1ns/1ps
// Functional notes
// - Reference below start frequency becomes zero
// - Clamp reference between start and maximum
// - Limit enable resets off; clamps floor/ceiling
// - No speed value above ceiling (maximum frequency writes are not checked against it); floor default
// - Floor and ceiling hidden while limit off
// - Never output a frequency inside bands
// - Rising reference holds at band lower edge
// - Three bands, skipped both directions, defaults
// - Alternate terminal selects alternate command, reference
// - Refuse alternate writes running on primary
// - Switching adopts new command state immediately
// - Start and maximum frequency defaults, ranges
module frl_limiter import frl_pkg::*; (
	input wire logic clk_in, // System clock
	input wire logic reset_in, // Synchronous reset
	input wire logic enable_in, // Clock enable
	input wire logic alternate_source_select_in, // Terminal pin
	input wire logic [2:0] primary_command_origin_in, // Primary cmd src
	input wire logic [3:0] primary_reference_origin_in, // Primary ref src
	input wire logic keypad_run_in, // Keypad run command
	input wire logic terminal_run_in, // Terminal run command
	input wire logic serial_run_in, // Serial link run command
	input wire logic [15:0] keypad_freq_in, // Keypad reference
	input wire logic [15:0] v1_freq_in, // Voltage input reference
	input wire logic [15:0] i2_freq_in, // Current input reference
	input wire logic [15:0] terminal_freq_in, // Terminal reference
	input wire logic [15:0] serial_freq_in, // Serial link reference
	input wire logic param_wr_in, // Parameter write strobe
	input wire logic [3:0] param_sel_in, // Parameter selector
	input wire logic [15:0] param_data_in, // Parameter write data
	output logic [15:0] param_rd_data_out, // Selected parameter value
	output logic write_refused_out, // Write refused pulse
	output logic alternate_active_out, // Alternate source in use
	output logic run_out, // Selected run command
	output logic [15:0] freq_ref_out // Final frequency reference
);

	frl_state_type st_q;
	frl_state_type st_d;
	logic [2:0] cmd_sel;
	logic [3:0] ref_sel;
	logic [15:0] ref_raw;
	logic run_sel;
	logic alt_run;
	logic [15:0] lo_lim;
	logic [15:0] hi_lim;
	logic [1:0] jidx;
	logic jsel;
	logic [3:0][15:0] chain;

	function automatic logic pick_run(input logic [2:0] c, input logic kp,
			input logic tm, input logic sr);
		if (c == FRL_CMD_KEYPAD) begin
			return kp;
		end else if (c == FRL_CMD_TERM1 || c == FRL_CMD_TERM2) begin
			return tm;
		end
		return sr;
	endfunction

	// ------------------------------------------------------------
	// Source selection
	// ------------------------------------------------------------
	assign cmd_sel = st_q.sync2 ? st_q.alt_cmd : primary_command_origin_in;
	assign ref_sel = st_q.sync2 ? st_q.alt_ref : primary_reference_origin_in;
	assign run_sel = pick_run(cmd_sel, keypad_run_in, terminal_run_in,
		serial_run_in);
	assign alt_run = pick_run(st_q.alt_cmd, keypad_run_in, terminal_run_in,
		serial_run_in);

	always_comb begin
		case (ref_sel)
			FRL_REF_KEYPAD1, FRL_REF_KEYPAD2: ref_raw = keypad_freq_in;
			FRL_REF_V1: ref_raw = v1_freq_in;
			FRL_REF_I2: ref_raw = i2_freq_in;
			FRL_REF_TERM_A, FRL_REF_TERM_B: ref_raw = terminal_freq_in;
			default: ref_raw = serial_freq_in;
		endcase
	end

	assign lo_lim = st_q.lim_en ? st_q.floor : st_q.start;
	assign hi_lim = st_q.lim_en ? st_q.ceil : st_q.maxf;
	assign jsel = (param_sel_in >= FRL_SEL_JLO0) &&
		(param_sel_in <= FRL_SEL_JHI2);
	assign jidx = 2'((param_sel_in - FRL_SEL_JLO0) >> 1);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.sync1 = alternate_source_select_in;
		st_d.sync2 = st_q.sync1;
		st_d.run = run_sel;
		st_d.refused = 1'b0;
		// Select, zero, clamp; band skipping follows in the stages
		if (ref_raw < st_q.start) begin
			st_d.cond = '0;
		end else if (ref_raw < lo_lim) begin
			st_d.cond = lo_lim;
		end else if (ref_raw > hi_lim) begin
			st_d.cond = hi_lim;
		end else begin
			st_d.cond = ref_raw;
		end
		if (param_wr_in) begin
			st_d.refused = 1'b1;
			case (param_sel_in)
				FRL_SEL_START: begin
					if (param_data_in >= FRL_START_MIN &&
							param_data_in <= FRL_START_MAX &&
							!(st_q.lim_en && param_data_in > st_q.ceil)) begin
						st_d.start = param_data_in;
						st_d.refused = 1'b0;
					end
				end
				FRL_SEL_MAXF: begin
					if (param_data_in >= FRL_MAXF_MIN &&
							param_data_in <= FRL_MAXF_MAX) begin
						st_d.maxf = param_data_in;
						st_d.refused = 1'b0;
					end
				end
				FRL_SEL_LIMEN: begin
					st_d.lim_en = param_data_in[0];
					st_d.refused = 1'b0;
				end
				FRL_SEL_FLOOR: begin
					if (st_q.lim_en && param_data_in <= st_q.maxf &&
							param_data_in <= st_q.ceil) begin
						st_d.floor = param_data_in;
						st_d.refused = 1'b0;
					end
				end
				FRL_SEL_CEIL: begin
					if (st_q.lim_en && param_data_in <= st_q.maxf &&
							param_data_in >= st_q.floor) begin
						st_d.ceil = param_data_in;
						st_d.refused = 1'b0;
					end
				end
				FRL_SEL_JUMPEN: begin
					st_d.jump_en = param_data_in[0];
					st_d.refused = 1'b0;
				end
				FRL_SEL_ALTCMD: begin
					if (!(st_q.run && !st_q.sync2)) begin
						st_d.alt_cmd = param_data_in[2:0];
						st_d.refused = 1'b0;
					end
				end
				FRL_SEL_ALTREF: begin
					if (!(st_q.run && !st_q.sync2)) begin
						st_d.alt_ref = param_data_in[3:0];
						st_d.refused = 1'b0;
					end
				end
				default: begin
					if (jsel && !(st_q.lim_en && param_data_in > st_q.ceil)) begin
						// Keep each band ordered and under the maximum
						if (!param_sel_in[0]) begin
							if (param_data_in <= st_q.jhi[jidx]) begin
								st_d.jlo[jidx] = param_data_in;
								st_d.refused = 1'b0;
							end
						end else if (param_data_in >= st_q.jlo[jidx] &&
								param_data_in <= st_q.maxf) begin
							st_d.jhi[jidx] = param_data_in;
							st_d.refused = 1'b0;
						end
					end
				end
			endcase
		end
		case (param_sel_in)
			FRL_SEL_START: st_d.rd_data = st_q.start;
			FRL_SEL_MAXF: st_d.rd_data = st_q.maxf;
			FRL_SEL_LIMEN: st_d.rd_data = {15'h0000, st_q.lim_en};
			FRL_SEL_FLOOR: st_d.rd_data = st_q.lim_en ? st_q.floor : '0;
			FRL_SEL_CEIL: st_d.rd_data = st_q.lim_en ? st_q.ceil : '0;
			FRL_SEL_JUMPEN: st_d.rd_data = {15'h0000, st_q.jump_en};
			FRL_SEL_ALTCMD: st_d.rd_data = {13'h0000, st_q.alt_cmd};
			FRL_SEL_ALTREF: st_d.rd_data = {12'h000, st_q.alt_ref};
			default: st_d.rd_data = jsel ? (param_sel_in[0] ?
				st_q.jhi[jidx] : st_q.jlo[jidx]) : '0;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st_q <= '0;
			st_q.start <= FRL_START_DEF;
			st_q.maxf <= FRL_MAXF_DEF;
			st_q.floor <= FRL_FLOOR_DEF;
			st_q.ceil <= FRL_CEIL_DEF;
			st_q.jlo <= FRL_JLO_DEF;
			st_q.jhi <= FRL_JHI_DEF;
			st_q.alt_cmd <= FRL_ALTCMD_DEF;
			st_q.alt_ref <= FRL_ALTREF_DEF;
		end else if (enable_in) begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// Jump band stages
	// ------------------------------------------------------------
	assign chain[0] = st_q.cond;
	for (genvar g = 0; g < 3; g++) begin : g_band
		frl_jump_stage u_stage (
			.clk_in(clk_in),
			.reset_in(reset_in),
			.enable_in(enable_in),
			.jump_on_in(st_q.jump_en),
			.band_lo_in(st_q.jlo[g]),
			.band_hi_in(st_q.jhi[g]),
			.ref_in(chain[g]),
			.ref_out(chain[g+1])
		);
	end

	assign freq_ref_out = chain[3];
	assign param_rd_data_out = st_q.rd_data;
	assign write_refused_out = st_q.refused;
	assign alternate_active_out = st_q.sync2;
	assign run_out = st_q.run;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_zero_below_start;
		@(posedge clk_in) disable iff (reset_in)
		enable_in && ref_raw < st_q.start |=> st_q.cond == 16'h0000;
	endproperty
	a_zero_below_start: assert property (p_zero_below_start)
		else $error("reference below start not zeroed");

	property p_clamp_max;
		@(posedge clk_in) disable iff (reset_in)
		enable_in && !st_q.lim_en && ref_raw >= st_q.start |=>
			st_q.cond >= $past(st_q.start) && st_q.cond <= $past(st_q.maxf);
	endproperty
	a_clamp_max: assert property (p_clamp_max)
		else $error("reference outside start..maximum");

	property p_clamp_limits;
		@(posedge clk_in) disable iff (reset_in)
		enable_in && st_q.lim_en && ref_raw >= st_q.start |=>
			st_q.cond >= $past(st_q.floor) && st_q.cond <= $past(st_q.ceil);
	endproperty
	a_clamp_limits: assert property (p_clamp_limits)
		else $error("reference outside floor..ceiling");

	property p_reset_defaults;
		@(posedge clk_in)
		reset_in |=> !st_q.lim_en && st_q.floor == FRL_FLOOR_DEF &&
			st_q.start == FRL_START_DEF && st_q.maxf == FRL_MAXF_DEF;
	endproperty
	a_reset_defaults: assert property (p_reset_defaults)
		else $error("wrong reset defaults");

	property p_ceiling_cap;
		@(posedge clk_in) disable iff (reset_in)
		enable_in && param_wr_in && param_sel_in == FRL_SEL_START &&
			st_q.lim_en && param_data_in > st_q.ceil |=>
			write_refused_out && $stable(st_q.start);
	endproperty
	a_ceiling_cap: assert property (p_ceiling_cap)
		else $error("speed value accepted above ceiling");

	property p_hidden_read;
		@(posedge clk_in) disable iff (reset_in)
		enable_in && !st_q.lim_en && (param_sel_in == FRL_SEL_FLOOR ||
			param_sel_in == FRL_SEL_CEIL) |=> param_rd_data_out == 16'h0000;
	endproperty
	a_hidden_read: assert property (p_hidden_read)
		else $error("hidden limit readable");

	property p_alt_run;
		@(posedge clk_in) disable iff (reset_in)
		enable_in && st_q.sync2 |=> run_out == $past(alt_run);
	endproperty
	a_alt_run: assert property (p_alt_run)
		else $error("alternate run command not followed");

	property p_alt_refuse;
		@(posedge clk_in) disable iff (reset_in)
		enable_in && param_wr_in && param_sel_in == FRL_SEL_ALTCMD &&
			st_q.run && !st_q.sync2 |=>
			write_refused_out && $stable(st_q.alt_cmd);
	endproperty
	a_alt_refuse: assert property (p_alt_refuse)
		else $error("alternate write accepted while running primary");

endmodule

// ===== rtl/frl_pkg.sv
package frl_pkg;

	// ------------------------------------------------------------
	// Frequency values in units of 0.01 Hz
	// ------------------------------------------------------------
	localparam int FRL_FREQ_W = 16;
	localparam logic [15:0] FRL_START_DEF = 16'h0032;
	localparam logic [15:0] FRL_START_MIN = 16'h0001;
	localparam logic [15:0] FRL_START_MAX = 16'h03E8;
	localparam logic [15:0] FRL_MAXF_DEF = 16'h1770;
	localparam logic [15:0] FRL_MAXF_MIN = 16'h0FA0;
	localparam logic [15:0] FRL_MAXF_MAX = 16'h9C40;
	localparam logic [15:0] FRL_FLOOR_DEF = 16'h0032;
	localparam logic [15:0] FRL_CEIL_DEF = 16'h1770;
	localparam logic [2:0][15:0] FRL_JLO_DEF = {16'h0BB8, 16'h07D0, 16'h03E8};
	localparam logic [2:0][15:0] FRL_JHI_DEF = {16'h0DAC, 16'h09C4, 16'h05DC};

	// ------------------------------------------------------------
	// Parameter selector codes
	// ------------------------------------------------------------
	localparam logic [3:0] FRL_SEL_START = 4'h0;
	localparam logic [3:0] FRL_SEL_MAXF = 4'h1;
	localparam logic [3:0] FRL_SEL_LIMEN = 4'h2;
	localparam logic [3:0] FRL_SEL_FLOOR = 4'h3;
	localparam logic [3:0] FRL_SEL_CEIL = 4'h4;
	localparam logic [3:0] FRL_SEL_JUMPEN = 4'h5;
	localparam logic [3:0] FRL_SEL_JLO0 = 4'h6;
	localparam logic [3:0] FRL_SEL_JHI2 = 4'hB;
	localparam logic [3:0] FRL_SEL_ALTCMD = 4'hC;
	localparam logic [3:0] FRL_SEL_ALTREF = 4'hD;

	// ------------------------------------------------------------
	// Source codes and reset values
	// ------------------------------------------------------------
	localparam logic [2:0] FRL_CMD_KEYPAD = 3'h0;
	localparam logic [2:0] FRL_CMD_TERM1 = 3'h1;
	localparam logic [2:0] FRL_CMD_TERM2 = 3'h2;
	localparam logic [3:0] FRL_REF_KEYPAD1 = 4'h0;
	localparam logic [3:0] FRL_REF_KEYPAD2 = 4'h1;
	localparam logic [3:0] FRL_REF_V1 = 4'h2;
	localparam logic [3:0] FRL_REF_I2 = 4'h3;
	localparam logic [3:0] FRL_REF_TERM_A = 4'h4;
	localparam logic [3:0] FRL_REF_TERM_B = 4'h5;
	localparam logic [2:0] FRL_ALTCMD_DEF = 3'h0;
	localparam logic [3:0] FRL_ALTREF_DEF = 4'h0;

	typedef struct packed {
		logic [15:0] out;
	} frl_stage_type;

	typedef struct packed {
		logic [15:0] start;
		logic [15:0] maxf;
		logic lim_en;
		logic [15:0] floor;
		logic [15:0] ceil;
		logic jump_en;
		logic [2:0][15:0] jlo;
		logic [2:0][15:0] jhi;
		logic [2:0] alt_cmd;
		logic [3:0] alt_ref;
		logic sync1;
		logic sync2;
		logic run;
		logic [15:0] cond;
		logic refused;
		logic [15:0] rd_data;
	} frl_state_type;

endpackage

// ===== rtl/frl_jump_stage.sv
`timescale 1ns/1ps
module frl_jump_stage import frl_pkg::*; (
	input wire logic clk_in, // System clock
	input wire logic reset_in, // Synchronous reset
	input wire logic enable_in, // Clock enable
	input wire logic jump_on_in, // Band skipping active
	input wire logic [15:0] band_lo_in, // Band lower edge
	input wire logic [15:0] band_hi_in, // Band upper edge
	input wire logic [15:0] ref_in, // Incoming reference
	output logic [15:0] ref_out // Reference with band skipped
);

	frl_stage_type st_q;
	frl_stage_type st_d;
	logic in_band;

	assign in_band = (ref_in > band_lo_in) && (ref_in < band_hi_in);

	// ------------------------------------------------------------
	// Band holding
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.out = ref_in;
		if (jump_on_in && in_band) begin
			// Hold the edge we arrived from
			if (st_q.out >= band_hi_in) begin
				st_d.out = band_hi_in;
			end else begin
				st_d.out = band_lo_in;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st_q <= '0;
		end else if (enable_in) begin
			st_q <= st_d;
		end
	end

	assign ref_out = st_q.out;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_never_in_band;
		@(posedge clk_in) disable iff (reset_in)
		enable_in && jump_on_in |=>
			!(ref_out > $past(band_lo_in) && ref_out < $past(band_hi_in));
	endproperty
	a_never_in_band: assert property (p_never_in_band)
		else $error("output inside jump band");

	property p_rise_hold_lo;
		@(posedge clk_in) disable iff (reset_in)
		enable_in && jump_on_in && in_band && st_q.out <= band_lo_in |=>
			ref_out == $past(band_lo_in);
	endproperty
	a_rise_hold_lo: assert property (p_rise_hold_lo)
		else $error("rising reference not held at lower edge");

	property p_fall_hold_hi;
		@(posedge clk_in) disable iff (reset_in)
		enable_in && jump_on_in && in_band && st_q.out >= band_hi_in |=>
			ref_out == $past(band_hi_in);
	endproperty
	a_fall_hold_hi: assert property (p_fall_hold_hi)
		else $error("falling reference not held at upper edge");

endmodule

// ===== verification/frl_source_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Keypad, analog inputs, terminals and serial link
// ------------------------------------------------------------
module frl_source_model (
	input wire logic [15:0] base_in, // Base reference
	input wire logic run_in, // Run level of chosen source
	input wire logic [1:0] run_src_in, // 0 keypad, 1 terminal, 2 serial
	input wire logic term_in, // Alternate terminal level
	output logic [15:0] keypad_out, // Keypad reference
	output logic [15:0] v1_out, // Voltage input reference
	output logic [15:0] i2_out, // Current input reference
	output logic [15:0] terminal_out, // Terminal reference
	output logic [15:0] serial_out, // Serial link reference
	output logic keypad_run_out, // Keypad run level
	output logic terminal_run_out, // Terminal run level
	output logic serial_run_out, // Serial run level
	output logic alt_pin_out // Terminal set to alternate function
);
	// Each source but the keypad offset so a wrong selection shows
	assign keypad_out = base_in;
	assign v1_out = base_in + 16'h0100;
	assign i2_out = base_in + 16'h0200;
	assign terminal_out = base_in + 16'h0300;
	assign serial_out = base_in + 16'h0400;
	// Unchosen sources carry the opposite run level
	assign keypad_run_out = (run_src_in == 2'h0) ? run_in : !run_in;
	assign terminal_run_out = (run_src_in == 2'h1) ? run_in : !run_in;
	assign serial_run_out = (run_src_in == 2'h2) ? run_in : !run_in;
	assign alt_pin_out = term_in;
endmodule

// ===== verification/tb_freq_reference_limiter.sv
`timescale 1ns/1ps
module tb_freq_reference_limiter import frl_pkg::*;;
	logic clk_in, reset_in, enable_in, wr, term, run, kr, tr, sr, alt;
	logic [1:0] run_src;
	logic [2:0] pcmd;
	logic [3:0] pref, sel;
	logic [15:0] base, data, kf, vf, if2, tf, sf, rd, fout;
	logic refused, alt_act, run_o;
	int fail_count, checks, i, b;
	logic [15:0] lo, hi;
	logic [13:0][15:0] rst_tab;

	// ------------------------------------------------------------
	// Design and sources
	// ------------------------------------------------------------
	frl_source_model src (.base_in(base), .run_in(run),
		.run_src_in(run_src), .term_in(term), .keypad_out(kf),
		.v1_out(vf), .i2_out(if2), .terminal_out(tf), .serial_out(sf),
		.keypad_run_out(kr), .terminal_run_out(tr), .serial_run_out(sr),
		.alt_pin_out(alt));
	frl_limiter dut (.clk_in(clk_in), .reset_in(reset_in),
		.enable_in(enable_in), .alternate_source_select_in(alt),
		.primary_command_origin_in(pcmd),
		.primary_reference_origin_in(pref), .keypad_run_in(kr),
		.terminal_run_in(tr), .serial_run_in(sr), .keypad_freq_in(kf),
		.v1_freq_in(vf), .i2_freq_in(if2), .terminal_freq_in(tf),
		.serial_freq_in(sf), .param_wr_in(wr), .param_sel_in(sel),
		.param_data_in(data), .param_rd_data_out(rd),
		.write_refused_out(refused), .alternate_active_out(alt_act),
		.run_out(run_o), .freq_ref_out(fout));

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = !clk_in;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(negedge clk_in);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr_par(input logic [3:0] s, input logic [15:0] d,
		input logic exp_ref);
		wr = 1'b1;
		sel = s;
		data = d;
		tick(1);
		wr = 1'b0;
		chk({15'h0000, refused}, {15'h0000, exp_ref});
		// Let an edge pass so a following write raises wr cleanly
		tick(1);
	endtask

	task automatic rd_par(input logic [3:0] s, input logic [15:0] exp);
		sel = s;
		tick(1);
		chk(rd, exp);
	endtask

	task automatic ref_chk(input logic [15:0] v, input logic [15:0] exp);
		base = v;
		tick(6);
		chk(fout, exp);
	endtask

	function automatic logic [15:0] src_ofs(input logic [3:0] r);
		case (r)
			4'h0, 4'h1: src_ofs = 16'h0000;
			4'h2: src_ofs = 16'h0100;
			4'h3: src_ofs = 16'h0200;
			4'h4, 4'h5: src_ofs = 16'h0300;
			default: src_ofs = 16'h0400;
		endcase
	endfunction

	task automatic results;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#100000;
		fail_count++;
		results;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		reset_in = 1'b1;
		enable_in = 1'b1;
		{wr, term, run} = 3'h0;
		run_src = 2'h0;
		{pcmd, pref, sel} = 11'h000;
		{base, data} = 32'h0000_0000;
		fail_count = 0;
		checks = 0;
		rst_tab = {16'h0000, 16'h0000, FRL_JHI_DEF[2], FRL_JLO_DEF[2],
			FRL_JHI_DEF[1], FRL_JLO_DEF[1], FRL_JHI_DEF[0],
			FRL_JLO_DEF[0], 16'h0000, 16'h0000, 16'h0000, 16'h0000,
			FRL_MAXF_DEF, FRL_START_DEF};
		tick(2);
		reset_in = 1'b0;
		for (i = 0; i < 14; i++) rd_par(i[3:0], rst_tab[i]);
		ref_chk(16'h0031, 16'h0000);
		ref_chk(16'h0032, 16'h0032);
		ref_chk(16'h2000, 16'h1770);
		wr_par(FRL_SEL_START, 16'h0000, 1'b1);
		wr_par(FRL_SEL_START, 16'h03E9, 1'b1);
		wr_par(FRL_SEL_START, 16'h03E8, 1'b0);
		ref_chk(16'h03E7, 16'h0000);
		wr_par(FRL_SEL_START, FRL_START_DEF, 1'b0);
		wr_par(FRL_SEL_MAXF, 16'h0F9F, 1'b1);
		wr_par(FRL_SEL_FLOOR, 16'h0100, 1'b1);
		wr_par(FRL_SEL_LIMEN, 16'h0001, 1'b0);
		rd_par(FRL_SEL_FLOOR, FRL_FLOOR_DEF);
		wr_par(FRL_SEL_CEIL, 16'h0FA0, 1'b0);
		wr_par(FRL_SEL_FLOOR, 16'h0100, 1'b0);
		wr_par(FRL_SEL_JHI2, 16'h1000, 1'b1);
		ref_chk(16'h1770, 16'h0FA0);
		ref_chk(16'h0080, 16'h0100);
		ref_chk(16'h0020, 16'h0000);
		wr_par(FRL_SEL_CEIL, 16'h0200, 1'b0);
		wr_par(FRL_SEL_START, 16'h0300, 1'b1);
		wr_par(FRL_SEL_LIMEN, 16'h0000, 1'b0);
		rd_par(FRL_SEL_CEIL, 16'h0000);
		wr_par(FRL_SEL_JUMPEN, 16'h0001, 1'b0);
		for (b = 0; b < 3; b++) begin
			lo = FRL_JLO_DEF[b];
			hi = FRL_JHI_DEF[b];
			ref_chk(lo - 16'h0001, lo - 16'h0001);
			ref_chk(lo + 16'h0010, lo);
			ref_chk(hi + 16'h0001, hi + 16'h0001);
			ref_chk(lo + 16'h0010, hi);
			ref_chk(lo - 16'h0001, lo - 16'h0001);
		end
		wr_par(FRL_SEL_JLO0, 16'h0600, 1'b1);
		wr_par(FRL_SEL_JUMPEN, 16'h0000, 1'b0);
		for (i = 0; i < 7; i++) begin
			pref = i[3:0];
			ref_chk(16'h0800, 16'h0800 + src_ofs(pref));
		end
		pref = 4'h0;
		run = 1'b1;
		tick(3);
		chk({15'h0000, run_o}, 16'h0001);
		wr_par(FRL_SEL_ALTCMD, 16'h0003, 1'b1);
		wr_par(FRL_SEL_ALTREF, 16'h0002, 1'b1);
		rd_par(FRL_SEL_ALTCMD, 16'h0000);
		run = 1'b0;
		tick(3);
		wr_par(FRL_SEL_ALTCMD, 16'h0003, 1'b0);
		wr_par(FRL_SEL_ALTREF, 16'h0002, 1'b0);
		run = 1'b1;
		term = 1'b1;
		ref_chk(16'h0800, 16'h0900);
		chk({15'h0000, alt_act}, 16'h0001);
		chk({15'h0000, run_o}, 16'h0000);
		run_src = 2'h2;
		tick(3);
		chk({15'h0000, run_o}, 16'h0001);
		term = 1'b0;
		ref_chk(16'h0800, 16'h0800);
		chk({15'h0000, alt_act}, 16'h0000);
		chk({15'h0000, run_o}, 16'h0000);
		// Clock enable low freezes the whole reference path
		enable_in = 1'b0;
		base = 16'h0700;
		tick(6);
		chk(fout, 16'h0800);
		enable_in = 1'b1;
		tick(6);
		chk(fout, 16'h0700);
		wr_par(FRL_SEL_MAXF, 16'h0FA0, 1'b0);
		ref_chk(16'h2000, 16'h0FA0);
		pcmd = FRL_CMD_TERM1;
		run_src = 2'h1;
		tick(3);
		chk({15'h0000, run_o}, 16'h0001);
		results;
	end
endmodule
